// file: assc_pkg.sv
// constants shared by the serial status/control block
// assumes an 8-bit register port and a 100 MHz core clock
package assc_pkg;
    // register word indices on the plain register port
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_CTRL1  = 2'h1;
    localparam logic [1:0] ADDR_CTRL2  = 2'h2;
    localparam logic [1:0] ADDR_DATA   = 2'h3;

    // status bit positions
    localparam int B_TX_EMPTY   = 7;
    localparam int B_TX_DONE    = 6;
    localparam int B_RX_READY   = 5;
    localparam int B_LINE_QUIET = 4;
    localparam int B_OVERRUN    = 3;
    localparam int B_NOISE      = 2;
    localparam int B_FRAMING    = 1;
    localparam int B_PARITY_ERR = 0;

    // control register 1 bit positions
    localparam int B_RX_NINTH   = 7;
    localparam int B_TX_NINTH   = 6;
    localparam int B_LP_OFF     = 5;
    localparam int B_WORD_NINE  = 4;
    localparam int B_WAKE_ADDR  = 3;
    localparam int B_PAR_EN     = 2;
    localparam int B_PAR_ODD    = 1;
    localparam int B_PAR_IRQ_EN = 0;

    // control register 2 interrupt enable positions
    localparam int B_TXE_IRQ_EN   = 7;
    localparam int B_TXD_IRQ_EN   = 6;
    localparam int B_RX_IRQ_EN    = 5;
    localparam int B_QUIET_IRQ_EN = 4;

    // reset values
    localparam logic [7:0] RST_STATUS = 8'hC0;
    localparam logic [7:0] RST_CTRL1  = 8'h00;
    localparam logic [3:0] RST_IRQ_EN = 4'h0;

    // status flags cleared by a status access then a data read
    localparam logic [7:0] RX_FLAG_MASK = 8'h3F;
    // status flags cleared by a status access then a data write
    localparam logic [7:0] TX_FLAG_MASK = 8'hC0;
endpackage

// file: assc_parity.sv
// parity generator over the low 7 or 8 bits of a word
// assumes purely combinational use by its parent
`timescale 1ns/10ps
`default_nettype none
module assc_parity (
    // word and format
    input  wire logic [8:0] i_word,
    input  wire logic       i_nine,
    input  wire logic       i_odd,
    // computed parity bit
    output logic            o_parity
);
    // even makes the ones count even, odd makes it odd
    always_comb begin
        o_parity = (i_nine ? (^i_word[7:0]) : (^i_word[6:0])) ^ i_odd;
    end
endmodule
`default_nettype wire

// file: assc_core.sv
// status and control part of the asynchronous serial unit
// assumes a bit engine outside that shifts frames and reports events,
// all inputs synchronous to i_ref_clk
//
// Summary of operation
// - Any enabled serial interrupt request while in wait mode wakes the processor.
// - Halt freezes all registers and traffic; no serial event ends halt.
// - All events except noise and framing share one request, each gated by its enable and global mask.
// - After reset status reads with tx empty and tx done set only.
// - Tx empty sets when holding data moves to the shifter; may interrupt.
// - Tx empty and tx done clear by status access then data write.
// - No holding to shifter transfer while tx empty is still set.
// - Tx done sets after a data frame, never after preamble or break.
// - Rx ready sets when a word is readable; rx flags clear by status then read.
// - Line quiet sets on idle line, not again until rx ready set after.
// - Overrun sets when a word completes while rx ready; held word is kept.
// - Noise flag sets on noisy frame, no interrupt of its own.
// - Framing flag has no interrupt; with overrun only overrun is set.
// - Parity error sets on failed check; interrupts with its enable.
// - Ctrl1 bit 7 holds received ninth bit, bit 6 supplies transmitted one.
// - Low power bit stops the engine after the current byte; clearing restarts.
// - Word length bit selects eight or nine data bits.
// - Wake method bit selects idle line or address mark wake.
// - Parity enable inserts parity at word msb and checks it from next byte.
// - Parity select picks even or odd, from the next byte on.
// - Parity interrupt enable gates the parity error onto the request.
`timescale 1ns/10ps
`default_nettype none
module assc_core
    import assc_pkg::*;
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // register port
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rd_data,
    // processor state
    input  wire logic       i_wait,
    input  wire logic       i_halt,
    input  wire logic       i_int_mask,
    // transmit engine
    input  wire logic       i_tx_shift_idle,
    input  wire logic       i_tx_frame_done,
    input  wire logic       i_tx_frame_data,
    output logic            o_tx_load,
    output logic      [8:0] o_tx_word,
    // receive engine
    input  wire logic       i_rx_busy,
    input  wire logic       i_rx_start,
    input  wire logic       i_rx_word_valid,
    input  wire logic [8:0] i_rx_word,
    input  wire logic       i_rx_noise,
    input  wire logic       i_rx_framing,
    input  wire logic       i_idle_detect,
    // engine configuration and requests
    output logic            o_serial_on,
    output logic            o_word_nine,
    output logic            o_wake_addr,
    output logic            o_irq,
    output logic            o_wait_exit
);
    // all state of the block
    typedef struct packed {
        logic [7:0] stat;
        logic [7:0] ctrl1;
        logic [3:0] irq_en;
        logic [7:0] tx_hold;
        logic [7:0] rx_hold;
        logic       stat_seen;
        logic [7:0] seen_mask;
        logic       idle_armed;
        logic       rx_nine;
        logic       rx_par_en;
        logic       rx_par_odd;
        logic       serial_on;
        logic [7:0] rd_data;
        logic       tx_load;
        logic [8:0] tx_word;
        logic       irq;
        logic       wait_exit;
    } assc_state_t;

    assc_state_t s_q;
    assc_state_t s_d;

    logic       tx_par;
    logic       rx_par;
    logic [8:0] tx_raw;
    logic       irq_req;
    logic       rx_bad_par;

    // raw transmit word with ninth bit from control register
    assign tx_raw = {s_q.ctrl1[B_TX_NINTH], s_q.tx_hold};

    // parity for the outgoing word
    assc_parity u_tx_par (
        .i_word   (tx_raw),
        .i_nine   (s_q.ctrl1[B_WORD_NINE]),
        .i_odd    (s_q.ctrl1[B_PAR_ODD]),
        .o_parity (tx_par)
    );

    // parity check of the incoming word, format latched at its start
    assc_parity u_rx_par (
        .i_word   (i_rx_word),
        .i_nine   (s_q.rx_nine),
        .i_odd    (s_q.rx_par_odd),
        .o_parity (rx_par)
    );

    // failed check compares against the word msb
    assign rx_bad_par = s_q.rx_par_en &
                        (rx_par != (s_q.rx_nine ? i_rx_word[8] : i_rx_word[7]));

    // shared request from every enabled flag
    assign irq_req = (s_q.stat[B_TX_EMPTY] & s_q.irq_en[B_TXE_IRQ_EN - 4])
                   | (s_q.stat[B_TX_DONE] & s_q.irq_en[B_TXD_IRQ_EN - 4])
                   | ((s_q.stat[B_RX_READY] | s_q.stat[B_OVERRUN])
                      & s_q.irq_en[B_RX_IRQ_EN - 4])
                   | (s_q.stat[B_LINE_QUIET] & s_q.irq_en[B_QUIET_IRQ_EN - 4])
                   | (s_q.stat[B_PARITY_ERR] & s_q.ctrl1[B_PAR_IRQ_EN]);

    // next state
    always_comb begin
        s_d = s_q;
        s_d.tx_load = 1'b0;
        // read data answer, one cycle after the strobe
        s_d.rd_data = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_STATUS: s_d.rd_data = s_q.stat;
                ADDR_CTRL1:  s_d.rd_data = s_q.ctrl1;
                ADDR_CTRL2:  s_d.rd_data = {s_q.irq_en, 4'h0};
                ADDR_DATA:   s_d.rd_data = s_q.rx_hold;
            endcase
        end
        // requests stay low in halt; only non-serial events end halt
        s_d.irq       = irq_req & ~i_int_mask & ~i_halt;
        s_d.wait_exit = irq_req & ~i_int_mask & ~i_halt & i_wait;
        if (!i_halt) begin
            // software side: clears first so hardware sets win
            if (i_rd && i_addr == ADDR_STATUS) begin
                s_d.stat_seen = 1'b1;
                s_d.seen_mask = s_q.stat;
            end
            if (i_wr && i_addr == ADDR_CTRL1) begin
                s_d.ctrl1[6:0] = i_wr_data[6:0];
            end
            if (i_wr && i_addr == ADDR_CTRL2) begin
                s_d.irq_en = i_wr_data[7:4];
            end
            if (i_wr && i_addr == ADDR_DATA) begin
                s_d.tx_hold = i_wr_data;
                if (s_q.stat_seen) begin
                    s_d.stat = s_d.stat & ~(s_q.seen_mask & TX_FLAG_MASK);
                end
                s_d.stat_seen = 1'b0;
            end
            if (i_rd && i_addr == ADDR_DATA) begin
                if (s_q.stat_seen) begin
                    s_d.stat = s_d.stat & ~(s_q.seen_mask & RX_FLAG_MASK);
                end
                s_d.stat_seen = 1'b0;
            end
            // low power takes hold only between bytes
            if (!s_q.ctrl1[B_LP_OFF]) begin
                s_d.serial_on = 1'b1;
            end else if (i_tx_shift_idle && !i_rx_busy && !s_q.tx_load) begin
                s_d.serial_on = 1'b0;
            end
            // hand holding data to the shifter once software refilled it
            if (!s_q.stat[B_TX_EMPTY] && i_tx_shift_idle && !s_q.tx_load &&
                s_q.serial_on) begin
                s_d.tx_load = 1'b1;
                s_d.tx_word = tx_raw;
                if (s_q.ctrl1[B_PAR_EN]) begin
                    if (s_q.ctrl1[B_WORD_NINE]) begin
                        s_d.tx_word[8] = tx_par;
                    end else begin
                        s_d.tx_word[7] = tx_par;
                    end
                end
                s_d.stat[B_TX_EMPTY] = 1'b1;
            end
            // completed frame carrying data
            if (i_tx_frame_done && i_tx_frame_data) begin
                s_d.stat[B_TX_DONE] = 1'b1;
            end
            // receive format fixed at the start of each word
            if (i_rx_start) begin
                s_d.rx_nine    = s_q.ctrl1[B_WORD_NINE];
                s_d.rx_par_en  = s_q.ctrl1[B_PAR_EN];
                s_d.rx_par_odd = s_q.ctrl1[B_PAR_ODD];
            end
            // word completed by the receive shifter
            if (i_rx_word_valid) begin
                if (s_q.stat[B_RX_READY]) begin
                    s_d.stat[B_OVERRUN] = 1'b1;
                end else begin
                    s_d.rx_hold = i_rx_word[7:0];
                    s_d.stat[B_RX_READY] = 1'b1;
                    s_d.idle_armed = 1'b1;
                    if (s_q.rx_nine) begin
                        s_d.ctrl1[B_RX_NINTH] = i_rx_word[8];
                    end
                    if (i_rx_noise) begin
                        s_d.stat[B_NOISE] = 1'b1;
                    end
                    if (i_rx_framing) begin
                        s_d.stat[B_FRAMING] = 1'b1;
                    end
                    if (rx_bad_par) begin
                        s_d.stat[B_PARITY_ERR] = 1'b1;
                    end
                end
            end
            // idle line, once per received word
            if (i_idle_detect && s_q.idle_armed) begin
                s_d.stat[B_LINE_QUIET] = 1'b1;
                s_d.idle_armed = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q            <= '0;
            s_q.stat       <= RST_STATUS;
            s_q.ctrl1      <= RST_CTRL1;
            s_q.irq_en     <= RST_IRQ_EN;
            s_q.idle_armed <= 1'b1;
            s_q.serial_on  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign o_rd_data   = s_q.rd_data;
    assign o_tx_load   = s_q.tx_load;
    assign o_tx_word   = s_q.tx_word;
    assign o_serial_on = s_q.serial_on;
    assign o_word_nine = s_q.ctrl1[B_WORD_NINE];
    assign o_wake_addr = s_q.ctrl1[B_WAKE_ADDR];
    assign o_irq       = s_q.irq;
    assign o_wait_exit = s_q.wait_exit;

    // checks
    AST_MASK_BLOCKS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $past(i_int_mask) |-> !o_irq)
        else $error("request raised while globally masked");

    AST_WAIT_WAKE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_wait && irq_req && !i_int_mask && !i_halt) |=> o_wait_exit)
        else $error("enabled event did not end wait");

    AST_HALT_FROZEN: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_halt |=> (s_q.stat == $past(s_q.stat)) && !o_irq && !o_tx_load)
        else $error("state moved during halt");

    AST_LOAD_ONLY_REFILLED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_tx_load |-> $past(!s_q.stat[B_TX_EMPTY]) && s_q.stat[B_TX_EMPTY])
        else $error("shifter load without refilled holding register");

    AST_NO_DONE_ON_BREAK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_tx_frame_done && !i_tx_frame_data && !s_q.stat[B_TX_DONE]) |=>
        !s_q.stat[B_TX_DONE])
        else $error("tx done set by preamble or break");

    AST_OVERRUN_KEEPS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_rx_word_valid && s_q.stat[B_RX_READY] && !i_halt) |=>
        s_q.stat[B_OVERRUN] && $stable(s_q.rx_hold) && s_q.stat[B_RX_READY])
        else $error("overrun not flagged or held word lost");

    AST_QUIET_ONCE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!s_q.idle_armed && !s_q.stat[B_LINE_QUIET] && !i_rx_word_valid) |=>
        !s_q.stat[B_LINE_QUIET])
        else $error("line quiet set again without new word");

    AST_PARITY_GATED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_q.stat[B_PARITY_ERR] && !s_q.ctrl1[B_PAR_IRQ_EN] && s_q.irq_en == 4'h0)
        |=> !o_irq)
        else $error("parity error raised request while disabled");

    AST_STATUS_READ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_rd && i_addr == ADDR_STATUS) |=> o_rd_data == $past(s_q.stat))
        else $error("status read returned wrong value");

    COV_TX_LOAD: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_tx_load);
    COV_OVERRUN: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(s_q.stat[B_OVERRUN]));
    COV_WAIT_EXIT: cover property (@(posedge i_ref_clk) disable iff (i_rst)
        o_wait_exit);
endmodule
`default_nettype wire

// file: assc_engine_model.sv
// far-side bit engine model: shifter timing and receive traffic
// assumes the bench calls its tasks between clock edges
`timescale 1ns/10ps
`default_nettype none
module assc_engine_model (
    // clock and load from the block
    input  wire logic       i_ref_clk,
    input  wire logic       i_tx_load,
    // transmit side
    output logic            o_shift_idle,
    output logic            o_frame_done,
    output logic            o_frame_data,
    // receive side
    output logic            o_rx_busy,
    output logic            o_rx_start,
    output logic            o_rx_valid,
    output logic      [8:0] o_rx_word,
    output logic            o_rx_noise,
    output logic            o_rx_framing,
    output logic            o_idle
);
    logic [3:0] cnt_q  = 4'h0;
    logic       idle_q = 1'b1;
    logic       done_q = 1'b0;
    logic       brk_q  = 1'b0;
    logic       tog_q  = 1'b0;
    // receive lines quiet at start
    initial begin
        o_rx_busy = 1'b0;
        o_rx_start = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_word = 9'h155;
        o_rx_noise = 1'b0;
        o_rx_framing = 1'b0;
        o_idle = 1'b0;
    end
    // shifter busy for a fixed frame time after each load
    always @(posedge i_ref_clk) begin
        done_q <= 1'b0;
        tog_q  <= ~tog_q;
        if (i_tx_load) begin
            idle_q <= 1'b0;
            cnt_q  <= 4'h9;
        end else if (!idle_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h0) begin
                idle_q <= 1'b1;
                done_q <= 1'b1;
            end
        end
    end
    // frame kind means something only beside a done pulse
    assign o_shift_idle = idle_q;
    assign o_frame_done = done_q | brk_q;
    assign o_frame_data = done_q | (~brk_q & tog_q);
    // a break frame ends without data
    task automatic tx_break();
        @(posedge i_ref_clk);
        brk_q <= 1'b1;
        @(posedge i_ref_clk);
        brk_q <= 1'b0;
    endtask
    // one received word; lines scrambled once it has been handed over
    task automatic rx_word(input logic [8:0] w, input logic nz, input logic fr);
        @(posedge i_ref_clk);
        o_rx_busy <= 1'b1;
        o_rx_start <= 1'b1;
        @(posedge i_ref_clk);
        o_rx_start <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        o_rx_valid <= 1'b1;
        o_rx_word <= w;
        o_rx_noise <= nz;
        o_rx_framing <= fr;
        o_rx_busy <= 1'b0;
        @(posedge i_ref_clk);
        o_rx_valid <= 1'b0;
        o_rx_word <= ~w;
        o_rx_noise <= ~nz;
        o_rx_framing <= ~fr;
    endtask
    // idle line seen
    task automatic idle_pulse();
        @(posedge i_ref_clk);
        o_idle <= 1'b1;
        @(posedge i_ref_clk);
        o_idle <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the serial status and control block
// assumes the engine model stands in for the bit engine
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import assc_pkg::*;
    typedef struct {logic [7:0] c, d, r; logic [1:0] nw; logic [8:0] w;} assc_txrow_t;
    typedef struct {logic [7:0] c; logic [8:0] w; logic nz, fr; logic [7:0] s, r;} assc_rxrow_t;
    logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_wait = 0, i_halt = 0, i_int_mask = 0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wr_data = 8'h00, o_rd_data, rdv;
    logic [8:0] o_tx_word, r_word, w;
    logic s_idle, f_done, f_data, o_tx_load, r_busy, r_start, r_valid, r_noise, r_fr, r_idle;
    logic o_serial_on, o_word_nine, o_wake_addr, o_irq, o_wait_exit;
    int err_total = 0, n_tests = 0;
    assc_txrow_t txt [6] = '{'{8'h00, 8'h35, 8'h00, 2'b00, 9'h035},
        '{8'h04, 8'hB5, 8'h04, 2'b00, 9'h035}, '{8'h06, 8'h35, 8'h06, 2'b00, 9'h0B5},
        '{8'h14, 8'h35, 8'h14, 2'b10, 9'h035}, '{8'h16, 8'h35, 8'h16, 2'b10, 9'h135},
        '{8'hD8, 8'h35, 8'h58, 2'b11, 9'h135}};
    assc_rxrow_t rxt [6] = '{'{8'h00, 9'h0A5, 0, 0, 8'h20, 8'h00},
        '{8'h00, 9'h0C3, 1, 0, 8'h24, 8'h00}, '{8'h00, 9'h03C, 0, 1, 8'h22, 8'h00},
        '{8'h04, 9'h07F, 0, 0, 8'h21, 8'h04}, '{8'h06, 9'h07F, 0, 0, 8'h20, 8'h06},
        '{8'h10, 9'h1A5, 0, 0, 8'h20, 8'h90}};
    // 100 MHz clock
    always #5 i_ref_clk = ~i_ref_clk;
    assc_core dut_u (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_wait(i_wait), .i_halt(i_halt),
        .i_int_mask(i_int_mask), .i_tx_shift_idle(s_idle), .i_tx_frame_done(f_done),
        .i_tx_frame_data(f_data), .o_tx_load(o_tx_load), .o_tx_word(o_tx_word),
        .i_rx_busy(r_busy), .i_rx_start(r_start), .i_rx_word_valid(r_valid),
        .i_rx_word(r_word), .i_rx_noise(r_noise), .i_rx_framing(r_fr), .i_idle_detect(r_idle),
        .o_serial_on(o_serial_on), .o_word_nine(o_word_nine), .o_wake_addr(o_wake_addr),
        .o_irq(o_irq), .o_wait_exit(o_wait_exit));
    assc_engine_model eng_u (
        .i_ref_clk(i_ref_clk), .i_tx_load(o_tx_load), .o_shift_idle(s_idle),
        .o_frame_done(f_done), .o_frame_data(f_data), .o_rx_busy(r_busy),
        .o_rx_start(r_start), .o_rx_valid(r_valid), .o_rx_word(r_word),
        .o_rx_noise(r_noise), .o_rx_framing(r_fr), .o_idle(r_idle));
    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // register port cycles
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 rdv = o_rd_data;
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        rd(ADDR_STATUS);
        chk(rdv & m, e);
    endtask
    // clear sequence then bounded wait for the shifter load
    task automatic tx(input logic [7:0] d);
        int k;
        rd(ADDR_STATUS);
        wr(ADDR_DATA, d);
        for (k = 0; k < 30 && o_tx_load !== 1'b1; k++) cyc(1);
        if (k == 30) begin
            err_total++;
            final_report();
        end
        w = o_tx_word;
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 40 && s_idle !== 1'b1; k++) cyc(1);
        if (k == 40) begin
            err_total++;
            final_report();
        end
        cyc(2);
    endtask
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        st(8'hFF, 8'hC0);
        rd(ADDR_CTRL1);
        chk(rdv, 8'h00);
        chk(o_serial_on, 1'b1);
        foreach (txt[i]) begin
            wr(ADDR_CTRL1, txt[i].c);
            rd(ADDR_CTRL1);
            chk(rdv, txt[i].r);
            chk({o_word_nine, o_wake_addr}, txt[i].nw);
            tx(txt[i].d);
            chk(w, txt[i].w);
            st(8'hFF, 8'h80);
            wait_idle();
            st(8'hFF, 8'hC0);
        end
        // break frame leaves transmit-done clear
        tx(8'h11);
        eng_u.tx_break();
        st(8'hFF, 8'h80);
        wait_idle();
        eng_u.idle_pulse();
        cyc(2);
        st(RX_FLAG_MASK, 8'h10);
        rd(ADDR_DATA);
        eng_u.idle_pulse();
        cyc(2);
        st(RX_FLAG_MASK, 8'h00);
        foreach (rxt[i]) begin
            wr(ADDR_CTRL1, rxt[i].c);
            eng_u.rx_word(rxt[i].w, rxt[i].nz, rxt[i].fr);
            cyc(2);
            st(RX_FLAG_MASK, rxt[i].s);
            rd(ADDR_DATA);
            chk(rdv, rxt[i].w[7:0]);
            rd(ADDR_CTRL1);
            chk(rdv, rxt[i].r);
            st(RX_FLAG_MASK, 8'h00);
        end
        eng_u.idle_pulse();
        cyc(2);
        st(RX_FLAG_MASK, 8'h10);
        rd(ADDR_DATA);
        // second word while the first is unread, with a framing fault
        eng_u.rx_word(9'h011, 1'b0, 1'b0);
        eng_u.rx_word(9'h022, 1'b0, 1'b1);
        cyc(2);
        st(RX_FLAG_MASK, 8'h28);
        rd(ADDR_DATA);
        chk(rdv, 8'h11);
        // shared request, mask, wait and halt
        wr(ADDR_CTRL2, 8'h80);
        cyc(2);
        chk(o_irq, 1'b1);
        @(posedge i_ref_clk);
        i_int_mask <= 1'b1;
        cyc(2);
        chk(o_irq, 1'b0);
        @(posedge i_ref_clk);
        i_int_mask <= 1'b0;
        i_wait <= 1'b1;
        cyc(2);
        chk(o_wait_exit, 1'b1);
        @(posedge i_ref_clk);
        i_halt <= 1'b1;
        cyc(2);
        chk(o_wait_exit, 1'b0);
        wr(ADDR_CTRL1, 8'h0F);
        rd(ADDR_CTRL1);
        chk(rdv, 8'h10);
        @(posedge i_ref_clk);
        i_halt <= 1'b0;
        i_wait <= 1'b0;
        wr(ADDR_CTRL2, 8'h00);
        wr(ADDR_CTRL1, 8'h05);
        eng_u.rx_word(9'h07F, 1'b0, 1'b0);
        cyc(2);
        chk(o_irq, 1'b1);
        wr(ADDR_CTRL1, 8'h04);
        cyc(2);
        chk(o_irq, 1'b0);
        wr(ADDR_CTRL1, 8'h20);
        cyc(3);
        chk(o_serial_on, 1'b0);
        wr(ADDR_CTRL1, 8'h00);
        cyc(3);
        chk(o_serial_on, 1'b1);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        st(8'hFF, 8'hC0);
        final_report();
    end
endmodule
`default_nettype wire
